// >>> pkg/npp_if.sv
// serial link between the page program device and its host controller
// assumes both parties drive enables; undriven lines read as pulled high
`timescale 1ns/100ps
interface npp_if;
  logic sclk;
  logic csN;
  logic [3:0] hostIo;
  logic [3:0] hostIoEn;
  logic [3:0] devIo;
  logic [3:0] devIoEn;
  logic [3:0] io;

  // wire level: host wins, then device, else pull-up
  assign io = (hostIoEn & hostIo) | (~hostIoEn & devIoEn & devIo) |
              (~hostIoEn & ~devIoEn);

  modport dev (input sclk, input csN, input io,
               output devIo, output devIoEn);
  modport host (output sclk, output csN, output hostIo, output hostIoEn,
                input io);
endinterface

// >>> pkg/npp_pkg.sv
// types for the page program device and its host controller
// assumes npp_regs.svh on the include path
package npp_pkg;
  `include "npp_regs.svh"

  typedef enum logic [2:0] {
    D_OPC = 3'h0,
    D_ADDR = 3'h1,
    D_DATA = 3'h2,
    D_WREN = 3'h3,
    D_STAT = 3'h4,
    D_SKIP = 3'h5
  } npp_dstate_t;

  typedef enum logic [2:0] {
    H_IDLE = 3'h0,
    H_HEAD = 3'h1,
    H_FETCH = 3'h2,
    H_DATA = 3'h3,
    H_READ = 3'h4,
    H_END = 3'h5
  } npp_hstate_t;

  typedef struct packed {
    logic [5:0] sync1;
    logic [5:0] sync2;
    logic prevSclk;
    logic prevCsN;
    npp_dstate_t state;
    logic [7:0] opcode;
    logic [7:0] shift;
    logic [4:0] bitCnt;
    logic [23:0] addr;
    logic [7:0] off;
    logic anyData;
    logic [255:0][7:0] pageBuf;
    logic [255:0] mask;
    logic write_enable_latch;
    logic busy;
    logic [8:0] engIdx;
    logic [31:0] timer;
    logic [7:0] statOut;
    logic dOut;
    logic dOutEn;
    logic memWrEn;
    logic [23:0] memWrAddr;
    logic [7:0] memWrData;
  } npp_dev_t;

  typedef struct packed {
    logic waitReq;
    logic [31:0] rdata;
    npp_hstate_t state;
    logic [1:0] cmd;
    logic [23:0] addr;
    logic [15:0] len;
    logic [15:0] remain;
    logic [31:0] sh;
    logic [5:0] bits;
    logic [3:0] div;
    logic sclk;
    logic csN;
    logic [3:0] ioOut;
    logic [3:0] ioEn;
    logic sync1;
    logic sync2;
    logic [7:0] srByte;
  } npp_host_t;
endpackage

// >>> pkg/npp_regs.svh
// constants shared by the page program device, its host and their package
// assumes inclusion by bare name; definitions only
`ifndef NPP_REGS_SVH
`define NPP_REGS_SVH

// ************************************************************
// instruction codes
// ************************************************************
`define NPP_OP_PROG 8'h02
`define NPP_OP_QPROG 8'h32
`define NPP_OP_WREN 8'h06
`define NPP_OP_RDSR 8'h05

// ************************************************************
// array geometry and protection granules
// ************************************************************
`define NPP_ADDR_BITS 24
`define NPP_PAGE_BYTES 256
`define NPP_SECTOR_SHIFT 12
`define NPP_BLOCK_SHIFT 16

// ************************************************************
// status byte layout
// ************************************************************
`define NPP_SR_WIP 0
`define NPP_SR_WEL 1
`define NPP_SR_BP_LSB 2

// ************************************************************
// timing
// ************************************************************
`define NPP_CLK_PERIOD_NS 10
`define NPP_PROG_TIME_NS 300000
`define NPP_PROG_CYCLES (`NPP_PROG_TIME_NS / `NPP_CLK_PERIOD_NS)
`define NPP_SCLK_HALF 8

// ************************************************************
// host register map (byte offsets) and fields
// ************************************************************
`define NPP_REG_CTRL 5'h00
`define NPP_REG_ADDR 5'h04
`define NPP_REG_LEN 5'h08
`define NPP_REG_DATA 5'h0C
`define NPP_REG_STAT 5'h10
`define NPP_STAT_BUSY 0
`define NPP_STAT_ROOM 1
`define NPP_STAT_SR_LSB 8
`define NPP_CMD_WREN 2'h0
`define NPP_CMD_PROG 2'h1
`define NPP_CMD_QPROG 2'h2
`define NPP_CMD_RDSR 2'h3
`define NPP_FIFO_DEPTH 8

`endif

// >>> src/npp_device.sv
// serial nor flash command front end for page and quad page program
// assumes the link comes from another clock domain (synchronised here)
// and that quadEnable and blockProtect come from logic on clk
`timescale 1ns/100ps
module npp_device #(
  parameter int PROG_CYCLES = `NPP_PROG_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // serial link
  npp_if.dev link,
  // configuration
  input wire logic quadEnable,
  input wire logic [4:0] blockProtect,
  // array write port
  output logic memWrEn,
  output logic [23:0] memWrAddr,
  output logic [7:0] memWrData,
  // status
  output logic writeInProgress,
  output logic writeEnableLatch
);
  `include "npp_regs.svh"

  npp_pkg::npp_dev_t r;
  npp_pkg::npp_dev_t n;

  // ************************************************************
  // protection decode
  // ************************************************************
  // bp[2:0] sets the region size, bp[3] picks bottom, bp[4] picks
  // sector rather than block granules
  function automatic logic isProtected(input logic [4:0] bp,
                                       input logic [23:0] a);
    logic [24:0] size;
    logic [24:0] full;
    full = 25'h1 << `NPP_ADDR_BITS;
    size = 25'h0;
    if (bp[2:0] == 3'h7) begin
      size = full;
    end else if (bp[2:0] != 3'h0) begin
      size = (25'h1 << (bp[4] ? `NPP_SECTOR_SHIFT : `NPP_BLOCK_SHIFT))
             << (bp[2:0] - 3'h1);
    end
    if (bp[3]) begin
      isProtected = {1'b0, a} < size;
    end else begin
      isProtected = {1'b0, a} >= (full - size);
    end
  endfunction

  // ************************************************************
  // next state
  // ************************************************************
  logic sclkS;
  logic csNS;
  logic [3:0] ioS;
  logic rise;
  logic fall;
  logic csRise;
  logic quad;
  logic [4:0] step;
  logic [7:0] nextByte;
  logic [7:0] liveStat;
  logic cmdOk;

  assign sclkS = r.sync2[5];
  assign csNS = r.sync2[4];
  assign ioS = r.sync2[3:0];
  assign rise = sclkS & ~r.prevSclk;
  assign fall = ~sclkS & r.prevSclk;
  assign csRise = csNS & ~r.prevCsN;
  assign quad = r.opcode == `NPP_OP_QPROG;
  assign step = quad ? 5'h4 : 5'h1;
  assign nextByte = quad ? {r.shift[3:0], ioS} : {r.shift[6:0], ioS[0]};

  always_comb begin
    liveStat = 8'h00;
    liveStat[`NPP_SR_WIP] = r.busy;
    liveStat[`NPP_SR_WEL] = r.write_enable_latch;
    liveStat[`NPP_SR_BP_LSB +: 5] = blockProtect;
  end

  // checked on the select rise that closes a program sequence
  assign cmdOk = r.write_enable_latch & ~r.busy &
                 (~quad | quadEnable) &
                 ~isProtected(blockProtect, r.addr);

  always_comb begin
    n = r;
    n.sync1 = {link.sclk, link.csN, link.io};
    n.sync2 = r.sync1;
    n.prevSclk = sclkS;
    n.prevCsN = csNS;
    n.memWrEn = 1'b0;

    // self-timed cycle: buffered bytes go out first, then the timer
    // runs out; unmarked bytes are never written
    if (r.busy) begin
      if (!r.engIdx[8]) begin
        n.memWrEn = r.mask[r.engIdx[7:0]];
        n.memWrAddr = {r.addr[23:8], r.engIdx[7:0]};
        n.memWrData = r.pageBuf[r.engIdx[7:0]];
        n.engIdx = r.engIdx + 9'h1;
      end
      n.timer = r.timer - 32'h1;
      if (r.timer == 32'h1) begin
        n.busy = 1'b0;
      end
    end

    if (csNS) begin
      if (csRise) begin
        if (r.state == npp_pkg::D_DATA && r.bitCnt == 5'h0 &&
            r.anyData && cmdOk) begin
          n.busy = 1'b1;
          n.timer = 32'(PROG_CYCLES);
          n.engIdx = 9'h0;
          n.write_enable_latch = 1'b0;
        end
        if (r.state == npp_pkg::D_WREN && !r.busy) begin
          n.write_enable_latch = 1'b1;
        end
      end
      n.state = npp_pkg::D_OPC;
      n.bitCnt = 5'h0;
      n.dOutEn = 1'b0;
      n.dOut = 1'b0;
    end else begin
      if (rise) begin
        case (r.state)
          npp_pkg::D_OPC: begin
            n.shift = {r.shift[6:0], ioS[0]};
            n.bitCnt = r.bitCnt + 5'h1;
            if (r.bitCnt == 5'h7) begin
              n.opcode = n.shift;
              n.bitCnt = 5'h0;
              case (n.shift)
                `NPP_OP_PROG, `NPP_OP_QPROG: begin
                  n.state = r.busy ? npp_pkg::D_SKIP : npp_pkg::D_ADDR;
                  n.mask = '0;
                  n.anyData = 1'b0;
                end
                `NPP_OP_WREN: begin
                  n.state = r.busy ? npp_pkg::D_SKIP : npp_pkg::D_WREN;
                end
                `NPP_OP_RDSR: begin
                  n.state = npp_pkg::D_STAT;
                  n.statOut = liveStat;
                end
                default: begin
                  n.state = npp_pkg::D_SKIP;
                end
              endcase
            end
          end
          npp_pkg::D_ADDR: begin
            n.addr = {r.addr[22:0], ioS[0]};
            n.bitCnt = r.bitCnt + 5'h1;
            if (r.bitCnt == 5'd23) begin
              n.state = npp_pkg::D_DATA;
              n.bitCnt = 5'h0;
              n.off = n.addr[7:0];
            end
          end
          npp_pkg::D_DATA: begin
            n.shift = nextByte;
            n.bitCnt = r.bitCnt + step;
            if (r.bitCnt + step == 5'h8) begin
              // overwrite in place so only the last 256 bytes survive
              n.pageBuf[r.off] = nextByte;
              n.mask[r.off] = 1'b1;
              n.off = r.off + 8'h1;              // wraps in page
              n.anyData = 1'b1;
              n.bitCnt = 5'h0;
            end
          end
          npp_pkg::D_WREN: begin
            n.state = npp_pkg::D_SKIP;
          end
          default: begin
          end
        endcase
      end
      // status shifts out on falling edges and refreshes each byte
      if (fall && r.state == npp_pkg::D_STAT) begin
        n.dOutEn = 1'b1;
        n.dOut = r.statOut[7];
        n.bitCnt = r.bitCnt + 5'h1;
        n.statOut = {r.statOut[6:0], 1'b0};
        if (r.bitCnt == 5'h7) begin
          n.bitCnt = 5'h0;
          n.statOut = liveStat;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r <= '0;
      r.sync1 <= 6'h10;
      r.sync2 <= 6'h10;
      r.prevCsN <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign link.devIo = {2'b00, r.dOut, 1'b0};
  assign link.devIoEn = {2'b00, r.dOutEn, 1'b0};
  assign memWrEn = r.memWrEn;
  assign memWrAddr = r.memWrAddr;
  assign memWrData = r.memWrData;
  assign writeInProgress = r.busy;
  assign writeEnableLatch = r.write_enable_latch;
endmodule

// >>> src/npp_fifo.sv
// small synchronous fifo with valid/ready on both sides
// assumes DEPTH is a power of two; one clock, async active-high reset
`timescale 1ns/100ps
module npp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } npp_fifo_t;

  npp_fifo_t r;
  npp_fifo_t n;
  logic push;
  logic pop;

  assign inReady = r.cnt != (AW+1)'(DEPTH);
  assign outValid = r.cnt != '0;
  assign outData = r.mem[r.rd];
  assign push = inValid & inReady;
  assign pop = outValid & outReady;

  always_comb begin
    n = r;
    if (push) begin
      n.mem[r.wr] = inData;
      n.wr = r.wr + AW'(1);
    end
    if (pop) begin
      n.rd = r.rd + AW'(1);
    end
    if (push & ~pop) begin
      n.cnt = r.cnt + (AW+1)'(1);
    end else if (pop & ~push) begin
      n.cnt = r.cnt - (AW+1)'(1);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
endmodule

// >>> src/npp_host.sv
// host controller issuing write enable, status read and page programs
// assumes software on Avalon-MM; device answer line arrives unsynchronised
`timescale 1ns/100ps
module npp_host (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // serial link
  npp_if.host link
);
  `include "npp_regs.svh"

  npp_pkg::npp_host_t r;
  npp_pkg::npp_host_t n;

  logic fifoInValid;
  logic fifoInReady;
  logic fifoOutValid;
  logic fifoOutReady;
  logic [7:0] fifoOutData;

  // ************************************************************
  // data fifo: software fills it, the shifter drains it
  // ************************************************************
  npp_fifo #(.WIDTH(8), .DEPTH(`NPP_FIFO_DEPTH)) u_npp_fifo (
    .clk(clk),
    .rst(rst),
    .inValid(fifoInValid),
    .inReady(fifoInReady),
    .inData(writedata[7:0]),
    .outValid(fifoOutValid),
    .outReady(fifoOutReady),
    .outData(fifoOutData)
  );

  // ************************************************************
  // next state
  // ************************************************************
  logic req;
  logic take;
  logic busy;
  logic quad;
  logic halfDone;
  logic [7:0] opc;

  assign req = read | write;
  assign take = req & ~r.waitReq;
  assign busy = r.state != npp_pkg::H_IDLE;
  assign quad = r.cmd == `NPP_CMD_QPROG;
  assign halfDone = r.div == 4'(`NPP_SCLK_HALF - 1);
  assign fifoInValid = take & write & (address == `NPP_REG_DATA);
  assign fifoOutReady = r.state == npp_pkg::H_FETCH;

  // decoded from the bus word, so the header needs no feedback from n
  always_comb begin
    case (writedata[1:0])
      `NPP_CMD_WREN: opc = `NPP_OP_WREN;
      `NPP_CMD_PROG: opc = `NPP_OP_PROG;
      `NPP_CMD_QPROG: opc = `NPP_OP_QPROG;
      default: opc = `NPP_OP_RDSR;
    endcase
  end

  always_comb begin
    n = r;
    n.sync1 = link.io[1];
    n.sync2 = r.sync1;

    // bus slave: one wait cycle, data writes wait for fifo room
    if (req && r.waitReq &&
        (!(write && address == `NPP_REG_DATA) || fifoInReady)) begin
      n.waitReq = 1'b0;
      case (address)
        `NPP_REG_CTRL: n.rdata = {30'h0, r.cmd};
        `NPP_REG_ADDR: n.rdata = {8'h00, r.addr};
        `NPP_REG_LEN: n.rdata = {16'h0000, r.len};
        `NPP_REG_STAT: begin
          n.rdata = 32'h0;
          n.rdata[`NPP_STAT_BUSY] = busy;
          n.rdata[`NPP_STAT_ROOM] = fifoInReady;
          n.rdata[`NPP_STAT_SR_LSB +: 8] = r.srByte;
        end
        default: n.rdata = 32'h0;
      endcase
    end
    if (take) begin
      n.waitReq = 1'b1;
      if (write) begin
        case (address)
          `NPP_REG_ADDR: n.addr = writedata[23:0];
          `NPP_REG_LEN: n.len = writedata[15:0];
          `NPP_REG_CTRL: begin
            // a start while busy is dropped
            if (!busy) begin
              n.cmd = writedata[1:0];
              n.state = npp_pkg::H_HEAD;
              n.csN = 1'b0;
              n.sclk = 1'b0;
              n.div = 4'h0;
              n.bits = 6'h0;
              n.remain = n.len;
              n.sh = {opc, n.addr};
            end
          end
          default: begin
          end
        endcase
      end
    end

    // shifter: data changes with sclk low, device samples on rise
    case (r.state)
      npp_pkg::H_HEAD, npp_pkg::H_DATA, npp_pkg::H_READ: begin
        n.div = r.div + 4'h1;
        if (halfDone) begin
          n.div = 4'h0;
          n.sclk = ~r.sclk;
          if (r.sclk) begin
            if (r.state == npp_pkg::H_DATA && quad) begin
              n.sh = {r.sh[27:0], 4'h0};
              n.bits = r.bits + 6'h4;
            end else begin
              n.sh = {r.sh[30:0], 1'b0};
              n.bits = r.bits + 6'h1;
            end
            if (r.state == npp_pkg::H_READ) begin
              n.srByte = {r.srByte[6:0], r.sync2};
            end
            if (r.state == npp_pkg::H_HEAD && n.bits == 6'h8 &&
                (r.cmd == `NPP_CMD_WREN || r.cmd == `NPP_CMD_RDSR)) begin
              n.state = r.cmd == `NPP_CMD_WREN ? npp_pkg::H_END :
                                                 npp_pkg::H_READ;
              n.bits = 6'h0;
            end else if (r.state == npp_pkg::H_HEAD && n.bits == 6'h20) begin
              n.state = npp_pkg::H_FETCH;
            end else if (r.state != npp_pkg::H_HEAD && n.bits == 6'h8) begin
              n.state = r.state == npp_pkg::H_READ ? npp_pkg::H_END :
                                                     npp_pkg::H_FETCH;
              n.remain = r.state == npp_pkg::H_DATA ? r.remain - 16'h1 :
                                                      r.remain;
            end
          end
        end
      end
      npp_pkg::H_FETCH: begin
        // select stays low while waiting for data
        if (r.remain == 16'h0) begin
          n.state = npp_pkg::H_END;
        end else if (fifoOutValid) begin
          n.sh = {fifoOutData, 24'h0};
          n.bits = 6'h0;
          n.state = npp_pkg::H_DATA;
        end
      end
      npp_pkg::H_END: begin
        n.csN = 1'b1;
        n.div = r.div + 4'h1;
        if (halfDone) begin
          n.div = 4'h0;
          n.state = npp_pkg::H_IDLE;
        end
      end
      default: begin
        // idle keeps select high unless a start was just taken
        n.csN = n.state == npp_pkg::H_IDLE;
      end
    endcase

    if (n.state == npp_pkg::H_DATA && quad) begin
      n.ioOut = n.sh[31:28];
      n.ioEn = 4'hF;
    end else begin
      n.ioOut = {3'h0, n.sh[31]};
      n.ioEn = (n.state == npp_pkg::H_HEAD || n.state == npp_pkg::H_DATA ||
                n.state == npp_pkg::H_FETCH) ? 4'h1 : 4'h0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r <= '0;
      r.waitReq <= 1'b1;
      r.csN <= 1'b1;
      r.sync1 <= 1'b1;
      r.sync2 <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign readdata = r.rdata;
  assign waitrequest = r.waitReq;
  assign link.sclk = r.sclk;
  assign link.csN = r.csN;
  assign link.hostIo = r.ioOut;
  assign link.hostIoEn = r.ioEn;
endmodule

// >>> testbench/nor_page_program_cmd_tb.sv
// bench: software writes reach the device through the host controller
// assumes npp_regs.svh on the include path; ends joined by npp_if
`timescale 1ns/100ps
`include "npp_regs.svh"
module nor_page_program_cmd_tb;
  localparam int PROG_CYC = 2000;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] address = 5'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h00000000;
  logic [31:0] readdata;
  logic waitrequest;
  logic quadEnable = 1'b0;
  logic [4:0] blockProtect = 5'h00;
  logic memWrEn;
  logic [23:0] memWrAddr;
  logic [7:0] memWrData;
  logic writeInProgress;
  logic writeEnableLatch;
  int fails = 0;
  int checked = 0;
  int wrCnt = 0;
  int wipLen = 0;
  int lastLen = 0;
  logic [15:0] wrPage;
  logic [7:0] seen [256];

  always #5 clk = ~clk;

  npp_if link ();
  npp_device #(.PROG_CYCLES(PROG_CYC)) u_npp_device (.clk(clk), .rst(rst),
    .link(link.dev), .quadEnable(quadEnable), .blockProtect(blockProtect),
    .memWrEn(memWrEn), .memWrAddr(memWrAddr), .memWrData(memWrData),
    .writeInProgress(writeInProgress), .writeEnableLatch(writeEnableLatch));
  npp_host u_npp_host (.clk(clk), .rst(rst), .address(address),
    .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .link(link.host));
  npp_properties u_npp_properties (.clk(clk), .rst(rst), .sclk(link.sclk),
    .csN(link.csN), .hostIo(link.hostIo), .hostIoEn(link.hostIoEn),
    .devIo(link.devIo), .devIoEn(link.devIoEn), .io(link.io));

  // ****************************************
  // array writes and program cycle length
  // ****************************************
  always @(posedge clk) begin
    wipLen <= (writeInProgress === 1'b1) ? wipLen + 1 : 0;
    if (writeInProgress === 1'b0 && wipLen != 0) lastLen <= wipLen;
    if (memWrEn === 1'b1) begin
      wrCnt <= wrCnt + 1;
      wrPage <= memWrAddr[23:8];
      seen[memWrAddr[7:0]] <= memWrData;
    end
  end

  // ****************************************
  // shared tasks
  // ****************************************
  function automatic logic [7:0] dat(input int k);
    return {k[8], k[6:0]};
  endfunction

  task automatic end_sim();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] got,
                     input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", n, exp, got);
    end
  endtask

  task automatic stuck(input string n);
    fails++;
    $display("FAIL %s expected answer seen none", n);
    end_sim();
  endtask

  // entered and left just after a rising edge
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    address <= a;
    writedata <= d;
    write <= w;
    read <= !w;
    @(posedge clk);
    while (waitrequest !== 1'b0) begin
      n++;
      if (n > 9000) stuck("waitrequest");
      @(posedge clk);
    end
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [4:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h00000000, q);
  endtask

  task automatic wait_idle();
    logic [31:0] q;
    int n;
    n = 0;
    q = 32'h00000001;
    while (q[0] !== 1'b0) begin
      n++;
      if (n > 3000) stuck("host idle");
      rd(`NPP_REG_STAT, q);
    end
  endtask

  task automatic wait_out(input logic write_enable_latch, input logic v, input int b);
    int n;
    n = 0;
    while ((write_enable_latch ? writeEnableLatch : writeInProgress) !== v) begin
      n++;
      if (n > b) stuck("status output");
      @(negedge clk);
    end
    @(posedge clk);
    @(posedge clk);
  endtask

  task automatic prog(input logic [1:0] c, input logic [23:0] a,
                      input int len);
    wr(`NPP_REG_ADDR, {8'h00, a});
    wr(`NPP_REG_LEN, 32'(len));
    wr(`NPP_REG_CTRL, {30'h0, c});
    for (int k = 0; k < len; k++) wr(`NPP_REG_DATA, {24'h0, dat(k)});
    wait_idle();
  endtask

  task automatic sr_read(output logic [31:0] q);
    wr(`NPP_REG_CTRL, {30'h0, `NPP_CMD_RDSR});
    wait_idle();
    rd(`NPP_REG_STAT, q);
  endtask

  task automatic set_latch();
    wr(`NPP_REG_CTRL, {30'h0, `NPP_CMD_WREN});
    wait_idle();
    wait_out(1'b1, 1'b1, 40);
    chk("latch set", writeEnableLatch, 1'b1);
  endtask

  task automatic expect_none(input int base);
    // a refusal shows at no port, so allow the commit delay and look
    repeat (40) @(posedge clk);
    chk("idle after refusal", writeInProgress, 1'b0);
    chk("writes after refusal", 32'(wrCnt - base), 32'h0);
  endtask

  task automatic expect_run(input int base, input int n,
                            input logic [15:0] pg);
    wait_out(1'b0, 1'b1, 40);
    chk("progress", writeInProgress, 1'b1);
    chk("latch", writeEnableLatch, 1'b0);
    wait_out(1'b0, 1'b0, PROG_CYC + 40);
    chk("cycle length", 32'(lastLen), 32'(PROG_CYC));
    chk("byte count", 32'(wrCnt - base), 32'(n));
    chk("page", wrPage, pg);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic s_refuse();
    logic [31:0] q;
    int base;
    base = wrCnt;
    rd(5'h14, q);
    chk("unmapped read", q, 32'h0);
    chk("latch at reset", writeEnableLatch, 1'b0);
    prog(`NPP_CMD_PROG, 24'h000100, 2);
    expect_none(base);
  endtask

  task automatic s_wrap();
    logic [31:0] q;
    int base;
    set_latch();
    base = wrCnt;
    prog(`NPP_CMD_PROG, 24'h0012FE, 4);
    wait_out(1'b0, 1'b1, 40);
    sr_read(q);
    chk("status busy", q[15:8], 8'h01);
    expect_run(base, 4, 16'h0012);
    for (int k = 0; k < 4; k++)
      chk("wrap data", seen[8'(254 + k)], dat(k));
  endtask

  task automatic s_over();
    int base;
    set_latch();
    base = wrCnt;
    prog(`NPP_CMD_PROG, 24'h000300, 258);
    expect_run(base, 256, 16'h0003);
    for (int j = 0; j < 256; j++)
      chk("last bytes", seen[j], dat(j < 2 ? j + 256 : j));
  endtask

  task automatic s_quad();
    int base;
    set_latch();
    base = wrCnt;
    prog(`NPP_CMD_QPROG, 24'h004010, 3);
    expect_none(base);
    chk("latch kept", writeEnableLatch, 1'b1);
    quadEnable <= 1'b1;
    prog(`NPP_CMD_QPROG, 24'h0040FF, 2);
    expect_run(base, 2, 16'h0040);
    chk("quad first", seen[8'hFF], dat(0));
    chk("quad wrap", seen[8'h00], dat(1));
  endtask

  task automatic s_protect();
    logic [31:0] q;
    int base;
    set_latch();
    blockProtect <= 5'h07;
    base = wrCnt;
    prog(`NPP_CMD_PROG, 24'hFFFF00, 1);
    expect_none(base);
    prog(`NPP_CMD_QPROG, 24'h000000, 1);
    expect_none(base);
    sr_read(q);
    chk("status protect", q[15:8], 8'h1E);
    blockProtect <= 5'h00;
  endtask

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    s_refuse();
    s_wrap();
    s_over();
    s_quad();
    s_protect();
    end_sim();
  end
endmodule

// >>> testbench/npp_properties.sv
// link checker for the page program host and device pair
// assumes instantiation beside the npp_if instance, sampled on clk
`timescale 1ns/100ps
`include "npp_regs.svh"
module npp_properties (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // serial link
  input wire logic sclk,
  input wire logic csN,
  input wire logic [3:0] hostIo,
  input wire logic [3:0] hostIoEn,
  input wire logic [3:0] devIo,
  input wire logic [3:0] devIoEn,
  input wire logic [3:0] io
);
  // ****************************************
  // clock edges counted inside a frame
  // ****************************************
  logic prevSclk;
  logic [15:0] edgeCnt;
  logic [15:0] bitCnt;
  logic [7:0] opc;

  // quad data rises carry four bits each, so bits are counted, not edges
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prevSclk <= 1'b0;
      edgeCnt <= 16'h0000;
      bitCnt <= 16'h0000;
      opc <= 8'h00;
    end else begin
      prevSclk <= sclk;
      if (csN) begin
        edgeCnt <= 16'h0000;
        bitCnt <= 16'h0000;
      end else if (sclk && !prevSclk) begin
        edgeCnt <= edgeCnt + 16'h0001;
        if (edgeCnt < 16'h0008) opc <= {opc[6:0], hostIo[0]};
        bitCnt <= bitCnt + ((opc == `NPP_OP_QPROG &&
                             edgeCnt >= 16'h0020) ? 16'h0004 : 16'h0001);
      end
    end
  end

  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence highPhase;
    sclk [*8] ##1 !sclk;
  endsequence
  sequence lowPhase;
    !sclk [*8];
  endsequence
  sequence selGap;
    csN [*8];
  endsequence

  idle_clock_low_a: assert property (csN |-> !sclk)
    else $error("serial clock high outside a frame");
  high_phase_a: assert property ($rose(sclk) |-> highPhase)
    else $error("clock high phase not 8 cycles");
  low_phase_a: assert property ($fell(sclk) |-> lowPhase)
    else $error("clock low phase under 8 cycles");
  bit_stable_a: assert property ($changed(hostIo) |-> !sclk)
    else $error("host line moved while clock high");
  byte_boundary_a: assert property ($rose(csN) |->
    bitCnt[2:0] == 3'h0 && bitCnt != 16'h0000)
    else $error("select rose off a byte boundary");
  select_gap_a: assert property ($rose(csN) |-> selGap)
    else $error("select high under 8 cycles");
  frame_start_a: assert property ($fell(csN) |-> ##[0:2] hostIoEn[0])
    else $error("host not driving line 0 in frame");
  line_owner_a: assert property (!(hostIoEn[1] && devIoEn[1]))
    else $error("both ends drive line 1");
  dev_line_a: assert property (devIoEn[1] && !hostIoEn[1] |->
    io[1] == devIo[1])
    else $error("status line not showing device value");
endmodule
